//--- rtl/fcp_top.sv
// Flash command, status and protection block with a Wishbone register slave
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Key-range write without enable starts a command
// - Key-range write with enable feeds key logic
// - Protection loads from stored byte at reset
// - Protection readable; software writes ignored
// - Debug port may change protect select bits
// - Select field marks end of unprotected region
// - Bit zero low protects, high disables protection
// - Protected program or erase ignored, violation set
// - Writing one clears protection violation
// - Launch by writing one; flag clears then
// - Only burst programs are buffered
// - Complete flag: buffer empty and idle, read-only
// - Sequence, divider or stop faults raise access error
// - Writing one clears access error, zero ignored
// - Blank flag set by clean blank check
// - Codes 05, 20, 25 decode check and programs
// - Codes 40 and 41 decode page, mass erase
// - Other codes raise access error
// - No program or erase before divider written
// - Flash clock is bus over prescale and divider
module fcp_top #(
  parameter int PULSES_PAGE = fcp_pkg::FCP_PULSES_PAGE,
  parameter int PULSES_MASS = fcp_pkg::FCP_PULSES_MASS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Nonvolatile, debug and system inputs
  input  wire logic [7:0]  stored_protection_byte_i,
  input  wire logic        dbg_prot_we_i,
  input  wire logic [7:0]  dbg_prot_dat_i,
  input  wire logic        stop_i,
  input  wire logic        all_erased_i,
  // Backdoor key writes
  output logic             key_we_o,
  output logic [2:0]       key_idx_o,
  output logic [7:0]       key_dat_o,
  // Array operation
  output logic             arr_start_o,
  output logic [7:0]       arr_cmd_o,
  output logic [15:0]      arr_addr_o,
  output logic [7:0]       arr_dat_o
);
  import fcp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fcp_exec_if ex_if ();

  logic [7:0]  clock_divider_register;
  logic [7:0]  flash_config_reg;
  logic [7:0]  flash_protection_reg;
  logic [7:0]  flash_command_reg;
  logic        buffer_empty_flag;
  logic        protection_violation_flag;
  logic        access_error_flag;
  logic        blank_verified_flag;
  logic        command_complete_flag;
  fcp_seq_t    seq_reg;
  logic [15:0] tgt_addr_reg;
  logic [7:0]  tgt_data_reg;
  logic        buf_valid_reg;
  logic [7:0]  buf_cmd_reg;
  logic [15:0] buf_addr_reg;
  logic [7:0]  buf_data_reg;
  logic        tick;

  logic        acc;
  logic        wr;
  logic        wr_div;
  logic        wr_cfg;
  logic        wr_stat;
  logic        wr_cmd;
  logic        wr_arr;
  logic        in_key;
  logic        key_write;
  logic        arr_step;
  logic        launch;
  logic        cmd_legal;
  logic        cmd_modifies;
  logic        cmd_protected;
  logic        launch_accerr;
  logic        launch_pviol;
  logic        launch_ok;
  logic        seq_accerr;
  logic        stop_accerr;
  logic        bef_set;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic legal_code(input logic [7:0] c);
    legal_code = (c == FCP_CMD_BLANK) || (c == FCP_CMD_BYTE) || (c == FCP_CMD_BURST)
                 || (c == FCP_CMD_PAGE) || (c == FCP_CMD_MASS);
  endfunction : legal_code

  function automatic logic is_protected(input logic [7:0] prot, input logic [15:0] a);
    is_protected = !prot[FCP_PROT_DIS_BIT]
                   && (a > {prot[7:1], {FCP_PAGE_BITS{1'b1}}});
  endfunction : is_protected

  // ----------------------------------------------------------------
  // Wishbone access decode
  // ----------------------------------------------------------------
  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = acc && wb_we_i && wb_sel_i[0];
  assign wr_div  = wr && (wb_adr_i == FCP_OFS_DIV);
  assign wr_cfg  = wr && (wb_adr_i == FCP_OFS_CONFIG);
  assign wr_stat = wr && (wb_adr_i == FCP_OFS_STATUS);
  assign wr_cmd  = wr && (wb_adr_i == FCP_OFS_COMMAND);
  assign wr_arr  = acc && wb_we_i && (wb_sel_i[2:0] == 3'h7) && (wb_adr_i == FCP_OFS_ARRAY);

  assign in_key    = (wb_dat_i[15:0] >= FCP_KEY_FIRST) && (wb_dat_i[15:0] <= FCP_KEY_LAST);
  assign key_write = wr_arr && in_key && flash_config_reg[FCP_CFG_KEYWE_BIT];
  assign arr_step  = wr_arr && !key_write;

  // ----------------------------------------------------------------
  // Command launch checks
  // ----------------------------------------------------------------
  assign launch        = wr_stat && wb_dat_i[FCP_ST_BEF_BIT];
  assign cmd_legal     = legal_code(flash_command_reg);
  assign cmd_modifies  = flash_command_reg != FCP_CMD_BLANK;
  assign cmd_protected = (flash_command_reg == FCP_CMD_MASS)
                         ? (!flash_protection_reg[FCP_PROT_DIS_BIT]
                            && (flash_protection_reg[7:1] != 7'h7F))
                         : is_protected(flash_protection_reg, tgt_addr_reg);
  assign launch_accerr = launch && ((seq_reg != FCP_SEQ_CMD)
                         || !cmd_legal
                         || !buffer_empty_flag
                         || (cmd_modifies && !clock_divider_register[FCP_DIV_LOADED_BIT])
                         || (ex_if.busy && ((flash_command_reg != FCP_CMD_BURST)
                                            || (arr_cmd_o != FCP_CMD_BURST))));
  assign launch_pviol  = launch && !launch_accerr && cmd_modifies && cmd_protected;
  assign launch_ok     = launch && !launch_accerr && !launch_pviol;
  assign seq_accerr    = (arr_step && (seq_reg == FCP_SEQ_CMD))
                         || (wr_cmd && (seq_reg != FCP_SEQ_ADDR));
  assign stop_accerr   = stop_i && ex_if.busy;
  assign bef_set       = (ex_if.taken && buf_valid_reg)
                         || (ex_if.done && !buf_valid_reg);

  // ----------------------------------------------------------------
  // Bus answer and read mux
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        unique case (wb_adr_i)
          FCP_OFS_DIV:     wb_dat_o <= {24'h000000, clock_divider_register};
          FCP_OFS_CONFIG:  wb_dat_o <= {24'h000000, flash_config_reg};
          FCP_OFS_PROT:    wb_dat_o <= {24'h000000, flash_protection_reg};
          FCP_OFS_STATUS:  wb_dat_o <= {24'h000000, buffer_empty_flag, command_complete_flag,
                                        protection_violation_flag, access_error_flag,
                                        1'b0, blank_verified_flag, 2'b00};
          FCP_OFS_COMMAND: wb_dat_o <= {24'h000000, flash_command_reg};
          FCP_OFS_ARRAY:   wb_dat_o <= {8'h00, tgt_data_reg, tgt_addr_reg};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_divider_register <= FCP_DIV_RST;
      flash_config_reg       <= FCP_CONFIG_RST;
    end else begin
      if (wr_div) clock_divider_register <= {1'b1, wb_dat_i[6:0]};
      if (wr_cfg) flash_config_reg <= {2'b00, wb_dat_i[FCP_CFG_KEYWE_BIT], 5'h00};
    end
  end

  // ----------------------------------------------------------------
  // Protection register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_protection_reg <= stored_protection_byte_i;
    end else if (dbg_prot_we_i) begin
      flash_protection_reg[7:1] <= dbg_prot_dat_i[7:1];
    end
  end

  // ----------------------------------------------------------------
  // Command sequence and key writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_reg           <= FCP_SEQ_IDLE;
      tgt_addr_reg      <= 16'h0000;
      tgt_data_reg      <= 8'h00;
      flash_command_reg <= FCP_CMD_RST;
      key_we_o          <= 1'b0;
      key_idx_o         <= 3'h0;
      key_dat_o         <= 8'h00;
    end else begin
      key_we_o <= key_write;
      if (key_write) begin
        key_idx_o <= wb_dat_i[2:0];
        key_dat_o <= wb_dat_i[23:16];
      end
      if (seq_accerr || launch) begin
        seq_reg <= FCP_SEQ_IDLE;
      end else if (arr_step) begin
        seq_reg      <= FCP_SEQ_ADDR;
        tgt_addr_reg <= wb_dat_i[15:0];
        tgt_data_reg <= wb_dat_i[23:16];
      end else if (wr_cmd) begin
        seq_reg           <= FCP_SEQ_CMD;
        flash_command_reg <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst buffer and executor start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_valid_reg <= 1'b0;
      buf_cmd_reg   <= 8'h00;
      buf_addr_reg  <= 16'h0000;
      buf_data_reg  <= 8'h00;
    end else begin
      if (ex_if.taken || stop_accerr) buf_valid_reg <= 1'b0;
      if (launch_ok) begin
        buf_valid_reg <= 1'b1;
        buf_cmd_reg   <= flash_command_reg;
        buf_addr_reg  <= tgt_addr_reg;
        buf_data_reg  <= tgt_data_reg;
      end
    end
  end

  assign ex_if.start = buf_valid_reg && !stop_i;
  assign ex_if.cmd   = buf_cmd_reg;
  assign ex_if.addr  = buf_addr_reg;
  assign ex_if.data  = buf_data_reg;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign command_complete_flag = buffer_empty_flag && !ex_if.busy && !buf_valid_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_empty_flag         <= 1'b1;
      protection_violation_flag <= 1'b0;
      access_error_flag         <= 1'b0;
      blank_verified_flag       <= 1'b0;
    end else begin
      if (launch_ok) buffer_empty_flag <= 1'b0;
      else if (bef_set || stop_accerr) buffer_empty_flag <= 1'b1;
      protection_violation_flag <= (protection_violation_flag
                                    && !(wr_stat && wb_dat_i[FCP_ST_PVIOL_BIT]))
                                   || launch_pviol;
      access_error_flag <= (access_error_flag
                            && !(wr_stat && wb_dat_i[FCP_ST_ACCERR_BIT]))
                           || launch_accerr || seq_accerr || stop_accerr;
      if (launch_ok) blank_verified_flag <= 1'b0;
      else if (ex_if.done && ex_if.blank) blank_verified_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Flash clock and executor
  // ----------------------------------------------------------------
  fcp_clkdiv u_clkdiv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .presc_i (clock_divider_register[FCP_DIV_PRESC_BIT]),
    .div_i   (clock_divider_register[5:0]),
    .tick_o  (tick)
  );

  fcp_exec #(
    .PULSES_PAGE (PULSES_PAGE),
    .PULSES_MASS (PULSES_MASS)
  ) u_exec (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (tick),
    .abort_i      (stop_i),
    .all_erased_i (all_erased_i),
    .ex           (ex_if.exec),
    .arr_start_o  (arr_start_o),
    .arr_cmd_o    (arr_cmd_o),
    .arr_addr_o   (arr_addr_o),
    .arr_dat_o    (arr_dat_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  prot_load_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i ##1 !rst_i |-> flash_protection_reg == $past(stored_protection_byte_i))
    else $error("prot not loaded");
  prot_ro_a: assert property (wr && wb_adr_i == FCP_OFS_PROT && !dbg_prot_we_i |=>
    $stable(flash_protection_reg)) else $error("prot changed by bus");
  dbg_select_a: assert property (dbg_prot_we_i |=>
    flash_protection_reg[7:1] == $past(dbg_prot_dat_i[7:1])) else $error("debug write lost");
  key_route_a: assert property (key_write |=> key_we_o && seq_reg == $past(seq_reg))
    else $error("key write misrouted");
  viol_set_a: assert property (launch_pviol |=> protection_violation_flag
    && !ex_if.start) else $error("violation not flagged");
  illegal_code_a: assert property (launch && seq_reg == FCP_SEQ_CMD && !cmd_legal |=>
    access_error_flag && !buf_valid_reg) else $error("illegal code accepted");
  div_gate_a: assert property (launch && cmd_modifies
    && !clock_divider_register[FCP_DIV_LOADED_BIT] |=> access_error_flag && !buf_valid_reg)
    else $error("program before divider");
  err_clear_a: assert property (access_error_flag && wr_stat && wb_dat_i[FCP_ST_ACCERR_BIT]
    && !launch_accerr && !seq_accerr && !stop_accerr |=> !access_error_flag)
    else $error("access error not cleared");
  launch_clr_a: assert property (launch_ok |=> !buffer_empty_flag
    ##[1:3] ex_if.busy) else $error("launch not started");
  ccf_idle_a: assert property (launch_ok |=> !command_complete_flag [*2])
    else $error("complete during command");

  burst_cov_c: cover property (launch_ok && ex_if.busy);
  blank_cov_c: cover property (ex_if.done && ex_if.blank);
  viol_cov_c:  cover property (launch_pviol);
  stop_cov_c:  cover property (stop_accerr);
endmodule : fcp_top

//--- rtl/fcp_pkg.sv
// Constants, register map and types for the flash command and protection block
package fcp_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FCP_OFS_DIV     = 8'h00;
  localparam logic [7:0] FCP_OFS_CONFIG  = 8'h04;
  localparam logic [7:0] FCP_OFS_PROT    = 8'h08;
  localparam logic [7:0] FCP_OFS_STATUS  = 8'h0C;
  localparam logic [7:0] FCP_OFS_COMMAND = 8'h10;
  localparam logic [7:0] FCP_OFS_ARRAY   = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCP_DIV_LOADED_BIT = 7;
  localparam int FCP_DIV_PRESC_BIT  = 6;
  localparam int FCP_CFG_KEYWE_BIT  = 5;
  localparam int FCP_PROT_DIS_BIT   = 0;
  localparam int FCP_ST_BEF_BIT     = 7;
  localparam int FCP_ST_CCF_BIT     = 6;
  localparam int FCP_ST_PVIOL_BIT   = 5;
  localparam int FCP_ST_ACCERR_BIT  = 4;
  localparam int FCP_ST_BLANK_BIT   = 2;
  localparam int FCP_PAGE_BITS      = 9;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FCP_DIV_RST    = 8'h00;
  localparam logic [7:0] FCP_CONFIG_RST = 8'h00;
  localparam logic [7:0] FCP_CMD_RST    = 8'h00;
  // ----------------------------------------------------------------
  // Command codes and key window
  // ----------------------------------------------------------------
  localparam logic [7:0]  FCP_CMD_BLANK  = 8'h05;
  localparam logic [7:0]  FCP_CMD_BYTE   = 8'h20;
  localparam logic [7:0]  FCP_CMD_BURST  = 8'h25;
  localparam logic [7:0]  FCP_CMD_PAGE   = 8'h40;
  localparam logic [7:0]  FCP_CMD_MASS   = 8'h41;
  localparam logic [15:0] FCP_KEY_FIRST  = 16'hFFB0;
  localparam logic [15:0] FCP_KEY_LAST   = 16'hFFB7;
  // ----------------------------------------------------------------
  // Flash clock pulse counts per command and prescaler count
  // ----------------------------------------------------------------
  localparam int FCP_PULSES_BYTE  = 9;
  localparam int FCP_PULSES_BURST = 4;
  localparam int FCP_PULSES_PAGE  = 4000;
  localparam int FCP_PULSES_MASS  = 20000;
  localparam int FCP_PULSES_BLANK = 16;
  localparam int FCP_PRESC_COUNT  = 8;

  typedef enum logic [1:0] {
    FCP_SEQ_IDLE,
    FCP_SEQ_ADDR,
    FCP_SEQ_CMD
  } fcp_seq_t;
endpackage : fcp_pkg

//--- rtl/fcp_exec_if.sv
// Handshake between command front end and array executor
`timescale 1ns/1ps
interface fcp_exec_if;
  logic        start;
  logic [7:0]  cmd;
  logic [15:0] addr;
  logic [7:0]  data;
  logic        busy;
  logic        taken;
  logic        done;
  logic        blank;
  modport front (output start, cmd, addr, data, input busy, taken, done, blank);
  modport exec  (input start, cmd, addr, data, output busy, taken, done, blank);
endinterface : fcp_exec_if

//--- rtl/fcp_clkdiv.sv
// Flash clock divider producing a one-cycle tick
`timescale 1ns/1ps
module fcp_clkdiv (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Divider setting
  input  wire logic       presc_i,
  input  wire logic [5:0] div_i,
  // Flash clock tick
  output logic            tick_o
);
  import fcp_pkg::*;

  logic [2:0] pre_reg;
  logic [5:0] cnt_reg;
  logic       pre_en;

  assign pre_en = !presc_i || (pre_reg == 3'(FCP_PRESC_COUNT - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || pre_en) pre_reg <= 3'h0;
    else pre_reg <= pre_reg + 3'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 6'h00;
      tick_o  <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (pre_en) begin
        if (cnt_reg >= div_i) begin
          cnt_reg <= 6'h00;
          tick_o  <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 6'h01;
        end
      end
    end
  end
endmodule : fcp_clkdiv

//--- rtl/fcp_exec.sv
// Array executor counting flash clock pulses per command
`timescale 1ns/1ps
module fcp_exec #(
  parameter int PULSES_PAGE = fcp_pkg::FCP_PULSES_PAGE,
  parameter int PULSES_MASS = fcp_pkg::FCP_PULSES_MASS
) (
  // Clock, reset, tick, abort, erased status and executor handshake
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  tick_i,
  input  wire logic  abort_i,
  input  wire logic  all_erased_i,
  fcp_exec_if.exec   ex,
  // Array side
  output logic        arr_start_o,
  output logic [7:0]  arr_cmd_o,
  output logic [15:0] arr_addr_o,
  output logic [7:0]  arr_dat_o
);
  import fcp_pkg::*;

  if (PULSES_PAGE < 1 || PULSES_PAGE > 65535
      || PULSES_MASS < 1 || PULSES_MASS > 65535) begin : g_bad_pulses
    $error("fcp_exec: pulse counts out of range");
  end

  logic [15:0] left_reg;
  logic        busy_reg;

  function automatic logic [15:0] pulses(input logic [7:0] c);
    unique case (c)
      FCP_CMD_BYTE:  pulses = 16'(FCP_PULSES_BYTE);
      FCP_CMD_BURST: pulses = 16'(FCP_PULSES_BURST);
      FCP_CMD_PAGE:  pulses = 16'(PULSES_PAGE);
      FCP_CMD_MASS:  pulses = 16'(PULSES_MASS);
      default:       pulses = 16'(FCP_PULSES_BLANK);
    endcase
  endfunction : pulses

  assign ex.busy  = busy_reg;
  assign ex.taken = ex.start && !busy_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg    <= 1'b0;
      left_reg    <= 16'h0000;
      ex.done     <= 1'b0;
      ex.blank    <= 1'b0;
      arr_start_o <= 1'b0;
      arr_cmd_o   <= 8'h00;
      arr_addr_o  <= 16'h0000;
      arr_dat_o   <= 8'h00;
    end else begin
      ex.done     <= 1'b0;
      arr_start_o <= 1'b0;
      if (ex.taken) begin
        busy_reg    <= 1'b1;
        left_reg    <= pulses(ex.cmd);
        arr_start_o <= 1'b1;
        arr_cmd_o   <= ex.cmd;
        arr_addr_o  <= ex.addr;
        arr_dat_o   <= ex.data;
      end else if (busy_reg && abort_i) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && tick_i) begin
        left_reg <= left_reg - 16'h0001;
        if (left_reg == 16'h0001) begin
          busy_reg <= 1'b0;
          ex.done  <= 1'b1;
          ex.blank <= (arr_cmd_o == FCP_CMD_BLANK) && all_erased_i;
        end
      end
    end
  end
endmodule : fcp_exec

//--- sim/fcp_flash_model.sv
// Behavioural flash array behind the command block
`timescale 1ns/1ps
module fcp_flash_model #(
  parameter logic [7:0] STORED = 8'h7E
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       arr_start_i,
  input  wire logic [7:0] arr_cmd_i,
  output logic [7:0]      stored_o,
  output logic            erased_o
);
  import fcp_pkg::*;
  assign stored_o = STORED;
  // Programs dirty the array, mass erase cleans it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erased_o <= 1'b1;
    end else if (arr_start_i && arr_cmd_i == FCP_CMD_MASS) begin
      erased_o <= 1'b1;
    end else if (arr_start_i && arr_cmd_i[7:4] == 4'h2) begin
      erased_o <= 1'b0;
    end
  end
endmodule : fcp_flash_model

//--- sim/fcp_top_tb.sv
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module fcp_top_tb;
  import fcp_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        dbg_we = 1'b0, ack, key_we, start, erased, stop = 1'b0;
  logic [15:0] arr_addr;
  logic [7:0]  arr_dat, key_dat;
  logic [2:0]  key_idx;
  logic [7:0]  adr = 8'h00, dbg_dat = 8'h00, stored, arr_cmd, last_cmd;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          n_errors = 0, cmp_count = 0, n_start = 0, n_key = 0, cyc_n = 0;
  logic [7:0]  codes [5] = '{FCP_CMD_BYTE, FCP_CMD_BURST, FCP_CMD_PAGE, FCP_CMD_MASS,
                             FCP_CMD_BLANK};
  fcp_top #(.PULSES_PAGE(3), .PULSES_MASS(3)) fcp_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stored_protection_byte_i(stored), .dbg_prot_we_i(dbg_we), .dbg_prot_dat_i(dbg_dat),
    .stop_i(stop), .all_erased_i(erased), .key_we_o(key_we), .key_idx_o(key_idx),
    .key_dat_o(key_dat), .arr_start_o(start), .arr_cmd_o(arr_cmd), .arr_addr_o(arr_addr),
    .arr_dat_o(arr_dat));
  fcp_flash_model fcp_flash_model_i (.clk_i(clk_i), .rst_i(rst_i), .arr_start_i(start),
    .arr_cmd_i(arr_cmd), .stored_o(stored), .erased_o(erased));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // Array starts, key writes and hang limit
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (start === 1'b1) begin
      n_start <= n_start + 1;
      last_cmd <= arr_cmd;
    end
    if (key_we === 1'b1) n_key <= n_key + 1;
    if (cyc_n == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string n);
    bus(1'b0, a, 32'h0);
    cmp(n, {24'h0, e}, q & {24'h0, m});
  endtask : rd
  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    bus(1'b1, FCP_OFS_ARRAY, {8'h00, 8'hA5, a});
    bus(1'b1, FCP_OFS_COMMAND, {24'h0, c});
    bus(1'b1, FCP_OFS_STATUS, 32'h80);
  endtask : launch
  task automatic wait_done;
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, FCP_OFS_STATUS, 32'h0);
      if (q[FCP_ST_CCF_BIT] === 1'b1) break;
    end
  endtask : wait_done
  initial begin
    int s;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(FCP_OFS_PROT, 8'hFF, 8'h7E, "prot_reset");
    bus(1'b1, FCP_OFS_PROT, 32'hFF);
    rd(FCP_OFS_PROT, 8'hFF, 8'h7E, "prot_write");
    rd(FCP_OFS_STATUS, 8'hC0, 8'hC0, "status_reset");
    launch(16'h0100, FCP_CMD_BYTE);
    rd(FCP_OFS_STATUS, 8'h10, 8'h10, "accerr_nodiv");
    bus(1'b1, FCP_OFS_STATUS, 32'h0);
    rd(FCP_OFS_STATUS, 8'h10, 8'h10, "accerr_w0");
    bus(1'b1, FCP_OFS_STATUS, 32'h10);
    rd(FCP_OFS_STATUS, 8'h10, 8'h00, "accerr_w1");
    cmp("starts_nodiv", 0, n_start);
    $display("test reset_divider done");
    bus(1'b1, FCP_OFS_DIV, 32'h03);
    launch(16'h8000, FCP_CMD_BYTE);
    rd(FCP_OFS_STATUS, 8'h30, 8'h20, "pviol_set");
    bus(1'b1, FCP_OFS_STATUS, 32'h20);
    rd(FCP_OFS_STATUS, 8'h20, 8'h00, "pviol_clr");
    launch(16'h0000, FCP_CMD_MASS);
    rd(FCP_OFS_STATUS, 8'h20, 8'h20, "pviol_mass");
    bus(1'b1, FCP_OFS_STATUS, 32'h20);
    cmp("starts_prot", 0, n_start);
    launch(16'h7FFF, FCP_CMD_BYTE);
    wait_done();
    cmp("starts_edge", 1, n_start);
    $display("test protection done");
    launch(16'h0100, 8'h33);
    rd(FCP_OFS_STATUS, 8'h10, 8'h10, "accerr_code");
    bus(1'b1, FCP_OFS_STATUS, 32'h10);
    bus(1'b1, FCP_OFS_COMMAND, {24'h0, FCP_CMD_BYTE});
    bus(1'b1, FCP_OFS_STATUS, 32'h80);
    rd(FCP_OFS_STATUS, 8'h10, 8'h10, "accerr_order");
    bus(1'b1, FCP_OFS_STATUS, 32'h10);
    cmp("starts_bad", 1, n_start);
    $display("test access_errors done");
    @(posedge clk_i);
    dbg_dat <= 8'hFF;
    dbg_we <= 1'b1;
    @(posedge clk_i);
    dbg_we <= 1'b0;
    rd(FCP_OFS_PROT, 8'hFF, 8'hFE, "prot_debug");
    for (int k = 0; k < 5; k++) begin
      s = n_start;
      launch(FCP_KEY_FIRST, codes[k]);
      rd(FCP_OFS_STATUS, 8'h40, 8'h00, "ccf_busy");
      wait_done();
      cmp("starts_code", s + 1, n_start);
      cmp("code_taken", {24'h0, codes[k]}, {24'h0, last_cmd});
      cmp("addr_taken", {16'h0, FCP_KEY_FIRST}, {16'h0, arr_addr});
      cmp("data_taken", 32'hA5, {24'h0, arr_dat});
    end
    bus(1'b1, FCP_OFS_STATUS, 32'h44);
    rd(FCP_OFS_STATUS, 8'hF4, 8'hC4, "blank_set");
    $display("test commands done");
    launch(16'h0200, FCP_CMD_BYTE);
    @(posedge clk_i);
    stop <= 1'b1;
    @(posedge clk_i);
    stop <= 1'b0;
    rd(FCP_OFS_STATUS, 8'hF4, 8'hD0, "stop_abort");
    bus(1'b1, FCP_OFS_STATUS, 32'h10);
    $display("test stop done");
    bus(1'b1, FCP_OFS_CONFIG, 32'h20);
    s = n_start;
    bus(1'b1, FCP_OFS_ARRAY, {8'h00, 8'h5A, FCP_KEY_LAST});
    repeat (3) @(posedge clk_i);
    cmp("key_writes", 1, n_key);
    cmp("starts_key", s, n_start);
    cmp("key_byte", {21'h0, 3'h7, 8'h5A}, {21'h0, key_idx, key_dat});
    $display("test key_window done");
    close_out();
  end
endmodule : fcp_top_tb
